// ### src/mfflg_pkg.sv
// constants for the memory access fault flag block
package mfflg_pkg;
  // register byte offsets on apb
  localparam logic [11:0] STATUS_OFF   = 12'h000;
  localparam logic [11:0] ADDR_OFF     = 12'h004;
  localparam logic [11:0] IRQ_EN_OFF   = 12'h008;
  localparam logic [11:0] IRQ_CLR_OFF  = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h010;
  // status field positions
  localparam int FETCH_BIT   = 0;
  localparam int DATA_BIT    = 1;
  localparam int RSVD_BIT    = 2;
  localparam int UNSTACK_BIT = 3;
  localparam int VALID_BIT   = 7;
  localparam int NUM_EVT     = 3;
  // reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
  localparam logic [2:0]  EVT_RST    = 3'h0;
  // fault kinds reported by the core
  typedef enum logic [1:0] {
    MFFLG_NONE,
    MFFLG_FETCH,
    MFFLG_DATA,
    MFFLG_UNSTACK
  } mfflg_kind_t;
endpackage

// ### src/mfflg_w1c_bit.sv
// one sticky flag, set by hardware, cleared by writing one
`timescale 1ns/1ns
module mfflg_w1c_bit (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // set and clear
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_q
);
  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// ### src/mfflg_apb_if.sv
// apb slave decode for the fault flag register file
`timescale 1ns/1ns
module mfflg_apb_if (
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  // decoded strobes
  output logic             wr_status,
  output logic             wr_en,
  output logic             wr_clr,
  output logic             wr_addr,
  output logic             rd_hit
);
  logic access;
  logic known;

  // zero wait state slave, unmapped offsets answer with pslverr
  always_comb begin
    access  = psel && penable;
    known   = (paddr == mfflg_pkg::STATUS_OFF) || (paddr == mfflg_pkg::ADDR_OFF) ||
              (paddr == mfflg_pkg::IRQ_EN_OFF) || (paddr == mfflg_pkg::IRQ_CLR_OFF) ||
              (paddr == mfflg_pkg::IRQ_STAT_OFF);
    pready    = 1'b1;
    pslverr   = access && !known;
    wr_status = access && pwrite && (paddr == mfflg_pkg::STATUS_OFF);
    wr_addr   = access && pwrite && (paddr == mfflg_pkg::ADDR_OFF);
    wr_en     = access && pwrite && (paddr == mfflg_pkg::IRQ_EN_OFF);
    wr_clr    = access && pwrite && (paddr == mfflg_pkg::IRQ_CLR_OFF);
    rd_hit    = access && !pwrite && known;
  end
endmodule

// ### src/mfflg_top.sv
// memory access fault flags with apb register file and interrupt
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns

module mfflg_top #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core fault reporting
  input  wire logic              fault_valid,
  input  wire mfflg_pkg::mfflg_kind_t fault_kind,
  input  wire logic              fault_xn_region,
  input  wire logic              fault_fetch_perm_ok,
  input  wire logic [ADDR_W-1:0] fault_addr,
  // exception directions back to the core
  output logic                   fault_take,
  output logic                   stack_pc_at_fault,
  output logic                   unstack_chain,
  output logic                   skip_sp_adjust,
  output logic                   skip_context_save,
  // interrupt
  output logic                   irq
);
  logic wr_status;
  logic wr_en;
  logic wr_clr;
  logic wr_addr;
  logic rd_hit;
  logic unstack_ev;
  logic data_ev;
  logic fetch_ev;
  logic capture;
  logic unstack_flag_q;
  logic data_flag_q;
  logic fetch_flag_q;
  logic valid_flag_q;
  logic [7:0]        status_w;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [2:0]        evt_en_q;
  logic [2:0]        evt_en_d;
  logic [2:0]        evt_st_q;
  logic [2:0]        evt_st_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;

  mfflg_apb_if u_apb (
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pready    (pready),
    .pslverr   (pslverr),
    .wr_status (wr_status),
    .wr_en     (wr_en),
    .wr_clr    (wr_clr),
    .wr_addr   (wr_addr),
    .rd_hit    (rd_hit)
  );

  // classify the reported fault
  always_comb begin
    unstack_ev = fault_valid && (fault_kind == mfflg_pkg::MFFLG_UNSTACK);
    data_ev    = fault_valid && (fault_kind == mfflg_pkg::MFFLG_DATA);
    // an execute-never hit faults whatever the protection unit says
    fetch_ev   = fault_valid && (fault_kind == mfflg_pkg::MFFLG_FETCH) &&
                 (fault_xn_region || !fault_fetch_perm_ok);
    capture    = data_ev;
  end

  // direction outputs are combinational so the core sees them with the fault
  always_comb begin
    fault_take        = unstack_ev || data_ev || fetch_ev;
    stack_pc_at_fault = data_ev || fetch_ev;
    unstack_chain     = unstack_ev;
    skip_sp_adjust    = unstack_ev;
    skip_context_save = unstack_ev;
  end

  // sticky flags, write one clears; writes of zero have no effect
  mfflg_w1c_bit u_unstack (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (unstack_ev),
    .clr_i   (wr_status && pwdata[mfflg_pkg::UNSTACK_BIT]),
    .flag_q  (unstack_flag_q)
  );
  mfflg_w1c_bit u_data (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (data_ev),
    .clr_i   (wr_status && pwdata[mfflg_pkg::DATA_BIT]),
    .flag_q  (data_flag_q)
  );
  mfflg_w1c_bit u_fetch (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (fetch_ev),
    .clr_i   (wr_status && pwdata[mfflg_pkg::FETCH_BIT]),
    .flag_q  (fetch_flag_q)
  );
  mfflg_w1c_bit u_valid (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (capture),
    .clr_i   (wr_status && pwdata[mfflg_pkg::VALID_BIT]),
    .flag_q  (valid_flag_q)
  );

  // status word; the reserved bit is hard zero and has no storage
  always_comb begin
    status_w = mfflg_pkg::STATUS_RST;
    status_w[mfflg_pkg::UNSTACK_BIT] = unstack_flag_q;
    status_w[mfflg_pkg::RSVD_BIT]    = 1'b0;
    status_w[mfflg_pkg::DATA_BIT]    = data_flag_q;
    status_w[mfflg_pkg::FETCH_BIT]   = fetch_flag_q;
    status_w[mfflg_pkg::VALID_BIT]   = valid_flag_q;
  end

  // address, interrupt enable and interrupt status next values
  always_comb begin
    addr_d   = addr_q;
    evt_en_d = evt_en_q;
    evt_st_d = evt_st_q;
    if (wr_addr) begin
      addr_d = pwdata[ADDR_W-1:0];
    end
    // hardware capture wins over a software write in the same cycle
    if (capture) begin
      addr_d = fault_addr;
    end
    if (wr_en) begin
      evt_en_d = pwdata[2:0];
    end
    if (wr_clr) begin
      evt_st_d = evt_st_q & ~pwdata[2:0];
    end
    evt_st_d = evt_st_d | {unstack_ev, data_ev, fetch_ev};
  end

  // read mux, registered on the access edge
  always_comb begin
    prdata_d = prdata_q;
    if (rd_hit) begin
      case (paddr)
        mfflg_pkg::STATUS_OFF:   prdata_d = {24'h000000, status_w};
        mfflg_pkg::ADDR_OFF:     prdata_d = 32'(addr_q);
        mfflg_pkg::IRQ_EN_OFF:   prdata_d = {29'h0, evt_en_q};
        mfflg_pkg::IRQ_STAT_OFF: prdata_d = {29'h0, evt_st_q};
        default:                 prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q   <= ADDR_W'(mfflg_pkg::ADDR_RST);
      evt_en_q <= mfflg_pkg::EVT_RST;
      evt_st_q <= mfflg_pkg::EVT_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      addr_q   <= addr_d;
      evt_en_q <= evt_en_d;
      evt_st_q <= evt_st_d;
      prdata_q <= prdata_d;
    end
  end

  // read data is combinational through the access phase so zero wait works
  always_comb begin
    prdata = prdata_q;
    if (rd_hit) begin
      prdata = prdata_d;
    end
    irq = |(evt_st_q & evt_en_q);
  end

  // assertions
  a_unstack_sets: assert property (@(posedge pclk) disable iff (!presetn)
    unstack_ev |=> unstack_flag_q)
    else $error("unstack fault did not set flag");
  a_unstack_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!unstack_flag_q && !unstack_ev) |=> !unstack_flag_q)
    else $error("unstack flag set without a fault");
  a_unstack_chain: assert property (@(posedge pclk) disable iff (!presetn)
    unstack_ev |-> unstack_chain && skip_sp_adjust && skip_context_save)
    else $error("unstack fault not chained");
  a_others_nochain: assert property (@(posedge pclk) disable iff (!presetn)
    (data_ev || fetch_ev) |-> !unstack_chain && !skip_sp_adjust && !skip_context_save)
    else $error("non unstack fault was chained");
  a_unstack_noaddr: assert property (@(posedge pclk) disable iff (!presetn)
    (unstack_ev && !data_ev && !wr_addr) |=> addr_q == $past(addr_q))
    else $error("unstack fault changed address");
  a_unstack_nocap: assert property (@(posedge pclk) disable iff (!presetn)
    unstack_ev |-> !capture)
    else $error("unstack fault captured an address");
  a_unstack_nopc: assert property (@(posedge pclk) disable iff (!presetn)
    unstack_ev |-> !stack_pc_at_fault)
    else $error("unstack fault asked for a new save");
  a_unstack_novalid: assert property (@(posedge pclk) disable iff (!presetn)
    (unstack_ev && !wr_status) |=> valid_flag_q == $past(valid_flag_q))
    else $error("unstack fault touched address valid flag");
  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_hit && paddr == mfflg_pkg::STATUS_OFF) |-> !prdata[mfflg_pkg::RSVD_BIT])
    else $error("reserved bit read nonzero");
  a_rsvd_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_status |=> !status_w[mfflg_pkg::RSVD_BIT])
    else $error("reserved bit took a write");
  a_data_sets: assert property (@(posedge pclk) disable iff (!presetn)
    data_ev |=> data_flag_q && valid_flag_q)
    else $error("data fault did not set flags");
  a_data_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!data_flag_q && !data_ev) |=> !data_flag_q)
    else $error("data flag set without a fault");
  a_data_addr: assert property (@(posedge pclk) disable iff (!presetn)
    data_ev |=> addr_q == $past(fault_addr))
    else $error("data fault address not captured");
  a_data_pc: assert property (@(posedge pclk) disable iff (!presetn)
    data_ev |-> fault_take && stack_pc_at_fault)
    else $error("data fault not taken at faulting pc");
  a_fetch_sets: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_ev |=> fetch_flag_q)
    else $error("fetch fault did not set flag");
  a_fetch_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!fetch_flag_q && !fetch_ev) |=> !fetch_flag_q)
    else $error("fetch flag set without a fault");
  a_fetch_perm: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_valid && fault_kind == mfflg_pkg::MFFLG_FETCH && !fault_fetch_perm_ok)
      |-> fetch_ev)
    else $error("denied fetch not flagged");
  a_fetch_allowed: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_valid && fault_kind == mfflg_pkg::MFFLG_FETCH && !fault_xn_region &&
      fault_fetch_perm_ok) |-> !fault_take)
    else $error("permitted fetch was faulted");
  a_fetch_xn: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_valid && fault_kind == mfflg_pkg::MFFLG_FETCH && fault_xn_region)
      |=> fetch_flag_q)
    else $error("execute never fetch not flagged");
  a_fetch_noaddr: assert property (@(posedge pclk) disable iff (!presetn)
    (fetch_ev && !wr_addr) |=> addr_q == $past(addr_q))
    else $error("fetch fault changed address");
  a_fetch_pc: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_ev |-> fault_take && stack_pc_at_fault)
    else $error("fetch fault not taken at faulting pc");
  a_fetch_novalid: assert property (@(posedge pclk) disable iff (!presetn)
    (fetch_ev && !wr_status) |=> valid_flag_q == $past(valid_flag_q))
    else $error("fetch fault touched address valid flag");
  a_addr_stable: assert property (@(posedge pclk) disable iff (!presetn)
    (!capture && !wr_addr) |=> addr_q == $past(addr_q))
    else $error("address changed with no cause");
  a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && !pwdata[mfflg_pkg::DATA_BIT] && data_flag_q) |=> data_flag_q)
    else $error("write zero cleared flag");
  a_zero_keeps_un: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && !pwdata[mfflg_pkg::UNSTACK_BIT] && unstack_flag_q) |=> unstack_flag_q)
    else $error("write zero cleared unstack flag");
  a_zero_keeps_fe: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && !pwdata[mfflg_pkg::FETCH_BIT] && fetch_flag_q) |=> fetch_flag_q)
    else $error("write zero cleared fetch flag");
  a_one_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[mfflg_pkg::FETCH_BIT] && !fetch_ev) |=> !fetch_flag_q)
    else $error("write one did not clear flag");
  a_unstack_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[mfflg_pkg::UNSTACK_BIT] && !unstack_ev) |=> !unstack_flag_q)
    else $error("write one did not clear unstack flag");
  a_data_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[mfflg_pkg::DATA_BIT] && !data_ev) |=> !data_flag_q)
    else $error("write one did not clear data flag");
  a_valid_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[mfflg_pkg::VALID_BIT] && !capture) |=> !valid_flag_q)
    else $error("write one did not clear valid flag");
  a_valid_sets: assert property (@(posedge pclk) disable iff (!presetn)
    capture |=> valid_flag_q)
    else $error("capture did not set valid flag");
  a_valid_only_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (!valid_flag_q && !capture) |=> !valid_flag_q)
    else $error("valid flag set without capture");
  // a clear may land in the second cycle, so both cycles must be write free
  a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ((unstack_flag_q && !wr_status) ##1 !wr_status) |-> unstack_flag_q [*2])
    else $error("flag dropped without clear");
  a_data_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (data_flag_q && !wr_status) |=> data_flag_q)
    else $error("data flag dropped without clear");
  a_fetch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (fetch_flag_q && !wr_status) |=> fetch_flag_q)
    else $error("fetch flag dropped without clear");
  a_no_fault_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !fault_valid |-> !fault_take && !unstack_chain && !stack_pc_at_fault)
    else $error("fault directions raised with no fault");
endmodule

// ### tb/mfflg_core_model.sv
// core-side fault reporter model for the fault flag block
`timescale 1ns/1ns
module mfflg_core_model (
  // clock
  input  wire logic             pclk,
  // exception directions seen from the block
  input  wire logic [4:0]       dirs,
  // fault report
  output logic                  fault_valid,
  output mfflg_pkg::mfflg_kind_t fault_kind,
  output logic                  fault_xn_region,
  output logic                  fault_fetch_perm_ok,
  output logic [31:0]           fault_addr
);
  initial begin
    fault_valid = 1'b0;
    fault_kind = mfflg_pkg::MFFLG_NONE;
    fault_xn_region = 1'b0;
    fault_fetch_perm_ok = 1'b1;
    fault_addr = 32'h0000_0000;
  end
  // one-cycle report; directions sampled once the launch edge has settled
  task automatic report(input mfflg_pkg::mfflg_kind_t k, input logic xn, input logic ok,
                        input logic [31:0] a, output logic [4:0] seen);
    @(posedge pclk);
    fault_valid <= 1'b1;
    fault_kind <= k;
    fault_xn_region <= xn;
    fault_fetch_perm_ok <= ok;
    fault_addr <= a;
    #1 seen = dirs;
    @(posedge pclk);
    fault_valid <= 1'b0;
    fault_kind <= mfflg_pkg::MFFLG_NONE;
    fault_addr <= ~a; // stale address is never left looking valid
  endtask
endmodule

// ### tb/memory_access_fault_flags_bench.sv
// self-checking bench for the memory access fault flags
`timescale 1ns/1ns
module memory_access_fault_flags_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, fa;
  logic pready, pslverr, err, irq, fv, xn, ok;
  wire  [4:0] dirs;
  logic [4:0] seen;
  mfflg_pkg::mfflg_kind_t fk;
  int mismatches = 0, tests_run = 0;
  always #50 pclk = ~pclk;
  mfflg_core_model core (.pclk(pclk), .dirs(dirs), .fault_valid(fv), .fault_kind(fk),
    .fault_xn_region(xn), .fault_fetch_perm_ok(ok), .fault_addr(fa));
  mfflg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_valid(fv), .fault_kind(fk), .fault_xn_region(xn),
    .fault_fetch_perm_ok(ok), .fault_addr(fa), .fault_take(dirs[4]),
    .stack_pc_at_fault(dirs[3]), .unstack_chain(dirs[2]), .skip_sp_adjust(dirs[1]),
    .skip_context_save(dirs[0]), .irq(irq));
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // a wait that ran out counts as a mismatch and ends the run
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  // each fault kind: directions in the fault cycle, then status and address
  task automatic faults;
    core.report(mfflg_pkg::MFFLG_DATA, 1'b0, 1'b1, 32'h1234_5678, seen);
    check(seen, 5'h18);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0082);
    rd_chk(mfflg_pkg::ADDR_OFF, 32'h1234_5678);
    core.report(mfflg_pkg::MFFLG_FETCH, 1'b0, 1'b1, 32'h0000_0abc, seen);
    check(seen, 5'h00);
    core.report(mfflg_pkg::MFFLG_FETCH, 1'b1, 1'b1, 32'h0000_0abc, seen);
    check(seen, 5'h18);
    core.report(mfflg_pkg::MFFLG_FETCH, 1'b0, 1'b0, 32'h0000_0abc, seen);
    check(seen, 5'h18);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0083);
    core.report(mfflg_pkg::MFFLG_UNSTACK, 1'b0, 1'b1, 32'h0000_0def, seen);
    check(seen, 5'h17);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_008b);
    rd_chk(mfflg_pkg::ADDR_OFF, 32'h1234_5678);
  endtask
  // write zero keeps, write one clears, a one written to the reserved bit still reads back zero
  task automatic clears;
    apb(1'b1, mfflg_pkg::STATUS_OFF, 32'h0000_0000);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_008b);
    apb(1'b1, mfflg_pkg::STATUS_OFF, (q & 32'h0000_0004) | 32'h0000_0006);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0089);
  endtask
  // interrupt raised, masked, cleared
  task automatic irqs;
    rd_chk(mfflg_pkg::IRQ_STAT_OFF, 32'h0000_0007);
    apb(1'b1, mfflg_pkg::IRQ_EN_OFF, 32'h0000_0004);
    #1 check(irq, 1'b1);
    apb(1'b1, mfflg_pkg::IRQ_EN_OFF, 32'h0000_0000);
    #1 check(irq, 1'b0);
    apb(1'b1, mfflg_pkg::IRQ_EN_OFF, 32'h0000_0007);
    apb(1'b1, mfflg_pkg::IRQ_CLR_OFF, 32'h0000_0007);
    #1 check(irq, 1'b0);
    rd_chk(mfflg_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    rd_chk(mfflg_pkg::IRQ_CLR_OFF, 32'h0000_0000);
    apb(1'b1, mfflg_pkg::STATUS_OFF, 32'h0000_0089);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0000);
  endtask
  // address register and an unmapped place
  task automatic regs;
    apb(1'b1, mfflg_pkg::ADDR_OFF, 32'hdead_beef);
    rd_chk(mfflg_pkg::ADDR_OFF, 32'hdead_beef);
    check(err, 1'b0);
    // a refused read leaves the previous read word on the bus
    rd_chk(12'h020, 32'hdead_beef);
    check(err, 1'b1);
  endtask
  // reset in mid-run wipes flags, captured address and interrupt state
  task automatic resets;
    core.report(mfflg_pkg::MFFLG_DATA, 1'b0, 1'b1, 32'h0000_5a5c, seen);
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0082);
    apb(1'b1, mfflg_pkg::IRQ_EN_OFF, 32'h0000_0007);
    #1 check(irq, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0000);
    rd_chk(mfflg_pkg::ADDR_OFF, 32'h0000_0000);
    rd_chk(mfflg_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    #1 check(irq, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(mfflg_pkg::STATUS_OFF, 32'h0000_0000);
    rd_chk(mfflg_pkg::ADDR_OFF, 32'h0000_0000);
    faults();
    clears();
    irqs();
    regs();
    resets();
    close_out();
  end
endmodule
